// ===== hdl/async_serial_port.sv
`default_nettype none
// Functional notes
// - frame starts after next divide-by-16 rollover
// - 10-bit: start, 8 data LSB first, stop
// - 11-bit: done flag rises with stop bit
// - receive only when enabled, 16x edge sampling
// - falling edge resets receive bit counter
// - majority vote of states 7, 8, 9
// - start bit not zero aborts reception
// - 10-bit receive: load buffer, stop into ninth
// - 11-bit receive: ninth bit, address filter
// - back to hunting; done flag blocks acceptance
// - 11-bit frame: start, 8 data, ninth, stop
// - buffer write captures transmit ninth bit
// - fixed mode: clock/64, or /32 doubled
// - shift mode: clock/12, or /4 selected
// - variable 11-bit uses generator rate
// - 15-bit up-counter, reload from byte pair
// - bit time 16 overflows plus fine trim
// - mask selects compared address bits
// - broadcast address is address OR mask
// - zero address and mask accept all
// - generator runs only when enable bit set
// - sticky framing error on low stop
// - sticky overrun when unread byte replaced
module async_serial_port #(
  parameter int FIFO_DEPTH = serial_port_pkg::TX_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic multiproc_select_i,
  input wire logic rx_enable_i,
  input wire logic baud_doubler_i,
  input wire logic tx_ninth_bit_i,
  input wire logic [7:0] slave_address_value_i,
  input wire logic [7:0] slave_address_mask_i,
  input wire logic [7:0] baud_reload_high_i,
  input wire logic [7:0] baud_reload_low_i,
  input wire logic [3:0] baud_fine_trim_reg_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_done_clear_i,
  input wire logic rx_done_clear_i,
  input wire logic rx_read_i,
  input wire logic framing_error_clear_i,
  input wire logic rx_overrun_clear_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic shift_tick_o,
  output logic tx_done_flag_o,
  output logic rx_done_flag_o,
  output logic [7:0] serial_data_buffer_o,
  output logic rx_ninth_bit_o,
  output logic framing_error_flag_o,
  output logic rx_overrun_flag_o
);
  localparam int WW = serial_port_pkg::TX_WORD_WIDTH;

  if (FIFO_DEPTH < 2) begin : g_bad
    $error("async_serial_port: FIFO_DEPTH too small");
  end

  typedef struct packed {
    logic rxd_s1;
    logic rxd_s2;
    logic rx_prev;
    logic [14:0] baud_cnt;
    logic [3:0] phase;
    logic [3:0] fine_cnt;
    logic fine_stall;
    logic [1:0] fix_cnt;
    logic [3:0] shift_cnt;
    logic shift_tick;
    serial_port_pkg::tx_state_t tx_state;
    logic tx_pend;
    logic [9:0] tx_shift;
    logic [3:0] tx_idx;
    logic [3:0] tx_cnt;
    logic txd;
    logic tx_done;
    serial_port_pkg::rx_state_t rx_state;
    logic [3:0] rx_cnt;
    logic [1:0] votes;
    logic [3:0] rx_idx;
    logic [8:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic rx_done;
    logic frame_err;
    logic ovr;
    logic unread;
  } port_state_t;

  port_state_t st_r, st_nxt;

  logic fifo_valid;
  logic fifo_pop;
  logic [WW-1:0] fifo_word;

  // ninth bit is sampled at the buffer write, not at frame start
  word_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i({tx_ninth_bit_i, tx_data_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_word)
  );

  logic eleven;
  logic gen_on;
  logic tick;
  logic tx_roll;
  logic sample;
  logic bit_val;
  logic [3:0] stop_idx;
  logic [7:0] bcast;
  logic addr_hit;
  logic accept;
  logic tx_set;
  logic err_set;
  logic ovr_set;

  assign eleven = mode_i[1];
  assign gen_on = baud_reload_high_i[serial_port_pkg::BAUD_ON_BIT];
  assign stop_idx = eleven ? serial_port_pkg::STOP_IDX11 : serial_port_pkg::STOP_IDX10;
  assign bcast = slave_address_value_i | slave_address_mask_i;
  // a zero mask and zero address make both terms true for any byte
  assign addr_hit = (((st_r.rx_shift[7:0] ^ slave_address_value_i) & slave_address_mask_i)
                     == 8'h00) || ((st_r.rx_shift[7:0] & bcast) == bcast);
  assign fifo_pop = fifo_valid && (st_r.tx_state == serial_port_pkg::TX_IDLE) && !st_r.tx_pend;

  always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    tx_roll = 1'b0;
    sample = 1'b0;
    bit_val = 1'b0;
    accept = 1'b0;
    tx_set = 1'b0;
    err_set = 1'b0;
    ovr_set = 1'b0;

    st_nxt.rxd_s1 = rxd_i;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    st_nxt.shift_tick = 1'b0;

    // 16x tick source per mode; shift mode drives only shift_tick
    case (mode_i)
      serial_port_pkg::MODE_SHIFT: begin
        if (st_r.shift_cnt == (multiproc_select_i ? serial_port_pkg::SHIFT_DIV_FAST
                                                  : serial_port_pkg::SHIFT_DIV_SLOW)) begin
          st_nxt.shift_cnt = 4'h0;
          st_nxt.shift_tick = 1'b1;
        end else begin
          st_nxt.shift_cnt = st_r.shift_cnt + 4'h1;
        end
      end
      serial_port_pkg::MODE_FIX11: begin
        if (st_r.fix_cnt == (baud_doubler_i ? serial_port_pkg::FIX_TICK_FAST
                                            : serial_port_pkg::FIX_TICK_SLOW)) begin
          st_nxt.fix_cnt = 2'h0;
          tick = 1'b1;
        end else begin
          st_nxt.fix_cnt = st_r.fix_cnt + 2'h1;
        end
      end
      default: begin
        // variable modes 1 and 3 share the generator
        if (!gen_on) begin
          st_nxt.baud_cnt = {baud_reload_high_i[6:0], baud_reload_low_i};
          st_nxt.phase = 4'h0;
          st_nxt.fine_stall = 1'b0;
        end else if (st_r.fine_stall) begin
          // extra clocks once per bit time, the fine trim
          if (st_r.fine_cnt == 4'h1) begin
            st_nxt.fine_stall = 1'b0;
          end
          st_nxt.fine_cnt = st_r.fine_cnt - 4'h1;
        end else if (st_r.baud_cnt == serial_port_pkg::BAUD_TOP) begin
          st_nxt.baud_cnt = {baud_reload_high_i[6:0], baud_reload_low_i};
          tick = 1'b1;
          st_nxt.phase = st_r.phase + 4'h1;
          if (st_r.phase == serial_port_pkg::PHASE_LAST && baud_fine_trim_reg_i != 4'h0) begin
            st_nxt.fine_stall = 1'b1;
            st_nxt.fine_cnt = baud_fine_trim_reg_i;
          end
        end else begin
          st_nxt.baud_cnt = st_r.baud_cnt + 15'h0001;
        end
      end
    endcase

    // transmitter: free divide-by-16 counter sets the bit grid
    if (tick) begin
      st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
      tx_roll = (st_r.tx_cnt == serial_port_pkg::BIT_LAST);
    end
    if (fifo_pop) begin
      st_nxt.tx_pend = 1'b1;
      // 10-bit frame gets two stop-level bits after the data
      st_nxt.tx_shift = {1'b1, eleven ? fifo_word[8] : 1'b1, fifo_word[7:0]};
    end
    case (st_r.tx_state)
      serial_port_pkg::TX_IDLE: begin
        st_nxt.txd = 1'b1;
        if (st_r.tx_pend && tx_roll) begin
          st_nxt.tx_pend = 1'b0;
          st_nxt.tx_state = serial_port_pkg::TX_SEND;
          st_nxt.txd = 1'b0;
          st_nxt.tx_idx = 4'h0;
        end
      end
      serial_port_pkg::TX_SEND: begin
        if (tx_roll) begin
          // also ends a frame left over from a longer mode
          if (st_r.tx_idx >= stop_idx) begin
            st_nxt.tx_state = serial_port_pkg::TX_IDLE;
            st_nxt.txd = 1'b1;
          end else begin
            st_nxt.txd = st_r.tx_shift[0];
            st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
            st_nxt.tx_idx = st_r.tx_idx + 4'h1;
            if (st_r.tx_idx + 4'h1 == stop_idx) begin
              st_nxt.tx_done = 1'b1;
              tx_set = 1'b1;
            end
          end
        end
      end
      default: begin
        st_nxt.tx_state = serial_port_pkg::TX_IDLE;
      end
    endcase
    // set wins over a clear in the same cycle
    if (tx_done_clear_i && !tx_set) begin
      st_nxt.tx_done = 1'b0;
    end

    // receiver
    if (tick) begin
      st_nxt.rx_prev = st_r.rxd_s2;
    end
    case (st_r.rx_state)
      serial_port_pkg::RX_HUNT: begin
        if (tick && rx_enable_i && mode_i != serial_port_pkg::MODE_SHIFT
            && st_r.rx_prev && !st_r.rxd_s2) begin
          st_nxt.rx_state = serial_port_pkg::RX_FRAME;
          st_nxt.rx_cnt = 4'h0;
          st_nxt.rx_idx = 4'h0;
          st_nxt.votes = 2'h0;
        end
      end
      serial_port_pkg::RX_FRAME: begin
        if (!rx_enable_i) begin
          st_nxt.rx_state = serial_port_pkg::RX_HUNT;
        end else if (tick) begin
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          if (st_r.rx_cnt == serial_port_pkg::VOTE_FIRST
              || st_r.rx_cnt == serial_port_pkg::VOTE_MID) begin
            st_nxt.votes = st_r.votes + {1'b0, st_r.rxd_s2};
          end
          if (st_r.rx_cnt == serial_port_pkg::VOTE_LAST) begin
            sample = 1'b1;
            bit_val = (st_r.votes == 2'h2) || (st_r.votes == 2'h1 && st_r.rxd_s2);
            st_nxt.votes = 2'h0;
          end
          if (st_r.rx_cnt == serial_port_pkg::BIT_LAST) begin
            st_nxt.rx_idx = st_r.rx_idx + 4'h1;
          end
        end
        if (sample) begin
          if (st_r.rx_idx == 4'h0) begin
            if (bit_val) begin
              st_nxt.rx_state = serial_port_pkg::RX_HUNT;
            end
          end else if (st_r.rx_idx == stop_idx) begin
            st_nxt.rx_state = serial_port_pkg::RX_HUNT;
            if (!bit_val) begin
              st_nxt.frame_err = 1'b1;
              err_set = 1'b1;
            end
            if (eleven) begin
              accept = !st_r.rx_done
                       && (!multiproc_select_i || (st_r.rx_shift[8] && addr_hit));
            end else begin
              accept = !st_r.rx_done && (!multiproc_select_i || bit_val);
            end
          end else begin
            st_nxt.rx_shift = {bit_val, st_r.rx_shift[8:1]};
          end
        end
      end
      default: begin
        st_nxt.rx_state = serial_port_pkg::RX_HUNT;
      end
    endcase

    // 10-bit frame leaves data in the upper eight shift bits
    if (accept) begin
      st_nxt.rx_data = eleven ? st_r.rx_shift[7:0] : st_r.rx_shift[8:1];
      st_nxt.rx_ninth = eleven ? st_r.rx_shift[8] : bit_val;
      st_nxt.rx_done = 1'b1;
      if (st_r.unread && !rx_read_i) begin
        st_nxt.ovr = 1'b1;
        ovr_set = 1'b1;
      end
      st_nxt.unread = 1'b1;
    end else if (rx_read_i) begin
      st_nxt.unread = 1'b0;
    end
    // hardware set wins over a clear in the same cycle
    if (rx_done_clear_i && !accept) begin
      st_nxt.rx_done = 1'b0;
    end
    if (framing_error_clear_i && !err_set) begin
      st_nxt.frame_err = 1'b0;
    end
    if (rx_overrun_clear_i && !ovr_set) begin
      st_nxt.ovr = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.rxd_s1 <= 1'b1;
      st_r.rxd_s2 <= 1'b1;
      st_r.rx_prev <= 1'b1;
      st_r.txd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txd_o = st_r.txd;
  assign shift_tick_o = st_r.shift_tick;
  assign tx_done_flag_o = st_r.tx_done;
  assign rx_done_flag_o = st_r.rx_done;
  assign serial_data_buffer_o = st_r.rx_data;
  assign rx_ninth_bit_o = st_r.rx_ninth;
  assign framing_error_flag_o = st_r.frame_err;
  assign rx_overrun_flag_o = st_r.ovr;
endmodule // async_serial_port
`default_nettype wire

// ===== hdl/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;
  // operating modes, two mode-select bits
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_VAR10 = 2'h1;
  localparam logic [1:0] MODE_FIX11 = 2'h2;
  localparam logic [1:0] MODE_VAR11 = 2'h3;
  // baud generator
  localparam int BAUD_WIDTH = 15;
  localparam logic [14:0] BAUD_TOP = 15'h7fff;
  localparam int BAUD_ON_BIT = 7;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  // fixed 11-bit mode: 16x tick every 4 clocks (clk/64) or 2 clocks (clk/32)
  localparam logic [1:0] FIX_TICK_SLOW = 2'h3;
  localparam logic [1:0] FIX_TICK_FAST = 2'h1;
  // shift mode divisors: clk/12 or clk/4
  localparam logic [3:0] SHIFT_DIV_SLOW = 4'hb;
  localparam logic [3:0] SHIFT_DIV_FAST = 4'h3;
  // divide-by-16 bit-time counter
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] VOTE_FIRST = 4'h6;
  localparam logic [3:0] VOTE_MID = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h8;
  // bit index of the stop bit, start bit counted as zero
  localparam logic [3:0] STOP_IDX10 = 4'h9;
  localparam logic [3:0] STOP_IDX11 = 4'ha;
  localparam int TX_FIFO_DEPTH = 16;
  localparam int TX_WORD_WIDTH = 9;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

  typedef enum logic [0:0] {
    RX_HUNT = 1'b0,
    RX_FRAME = 1'b1
  } rx_state_t;
endpackage
`default_nettype wire

// ===== hdl/word_fifo.sv
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("word_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_r, st_nxt;
  logic push, pop;

  assign in_ready_o = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.count != '0);
  assign out_data_o = st_r.mem[st_r.rd];

  always_comb begin
    st_nxt = st_r;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data_i;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // word_fifo
`default_nettype wire

// ===== tb/async_serial_port_asserts.sv
`default_nettype none
module async_serial_port_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic multiproc_select_i,
  input wire logic rx_enable_i,
  input wire logic [7:0] slave_address_value_i,
  input wire logic [7:0] slave_address_mask_i,
  input wire logic tx_done_clear_i,
  input wire logic framing_error_clear_i,
  input wire logic rx_overrun_clear_i,
  input wire logic txd_o,
  input wire logic shift_tick_o,
  input wire logic tx_done_flag_o,
  input wire logic rx_done_flag_o,
  input wire logic [7:0] serial_data_buffer_o,
  input wire logic rx_ninth_bit_o,
  input wire logic framing_error_flag_o,
  input wire logic rx_overrun_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bcast;
  logic addr_hit;
  assign bcast = slave_address_value_i | slave_address_mask_i;
  assign addr_hit = ((((serial_data_buffer_o ^ slave_address_value_i) & slave_address_mask_i)
    == 8'h00) || ((serial_data_buffer_o & bcast) == bcast));
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_tick_fast_period: assert property (
    shift_tick_o && multiproc_select_i |-> ##1 !shift_tick_o [*3] ##1 shift_tick_o)
    else $error("shift tick not every 4 clocks");
  a_tick_slow_period: assert property (
    shift_tick_o && !multiproc_select_i |-> ##1 !shift_tick_o [*8] ##1 !shift_tick_o [*3]
    ##1 shift_tick_o) else $error("shift tick not every 12 clocks");
  a_tick_mode_only: assert property (
    shift_tick_o |-> $past(mode_i) == serial_port_pkg::MODE_SHIFT)
    else $error("shift tick outside shift mode");
  a_done_with_stop: assert property ($rose(tx_done_flag_o) |-> txd_o)
    else $error("tx done rose without stop level");
  a_tx_done_held: assert property (tx_done_flag_o && !tx_done_clear_i |=> tx_done_flag_o)
    else $error("tx done dropped without clear");
  a_rx_needs_enable: assert property ($rose(rx_done_flag_o) |->
    $past(rx_enable_i) && $past(mode_i) != serial_port_pkg::MODE_SHIFT)
    else $error("frame taken while receive disabled");
  a_rx_done_holds: assert property (rx_done_flag_o |=>
    $stable(serial_data_buffer_o) && $stable(rx_ninth_bit_o))
    else $error("buffer changed while rx done set");
  a_stop_low_error: assert property ($rose(rx_done_flag_o) &&
    $past(mode_i) == serial_port_pkg::MODE_VAR10 && !rx_ninth_bit_o |-> framing_error_flag_o)
    else $error("low stop taken without framing error");
  a_filter_ninth_hit: assert property ($rose(rx_done_flag_o) &&
    $past(multiproc_select_i) && $past(mode_i[1]) |-> rx_ninth_bit_o && addr_hit)
    else $error("filtered frame taken without address hit");
  a_fe_sticky: assert property (
    framing_error_flag_o && !framing_error_clear_i |=> framing_error_flag_o)
    else $error("framing error dropped without clear");
  a_overrun_sticky: assert property (
    rx_overrun_flag_o && !rx_overrun_clear_i |=> rx_overrun_flag_o)
    else $error("overrun dropped without clear");
endmodule // async_serial_port_asserts

bind async_serial_port async_serial_port_asserts chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .multiproc_select_i(multiproc_select_i),
  .rx_enable_i(rx_enable_i), .slave_address_value_i(slave_address_value_i),
  .slave_address_mask_i(slave_address_mask_i), .tx_done_clear_i(tx_done_clear_i),
  .framing_error_clear_i(framing_error_clear_i), .rx_overrun_clear_i(rx_overrun_clear_i),
  .txd_o(txd_o), .shift_tick_o(shift_tick_o), .tx_done_flag_o(tx_done_flag_o),
  .rx_done_flag_o(rx_done_flag_o), .serial_data_buffer_o(serial_data_buffer_o),
  .rx_ninth_bit_o(rx_ninth_bit_o), .framing_error_flag_o(framing_error_flag_o),
  .rx_overrun_flag_o(rx_overrun_flag_o)
);
`default_nettype wire

// ===== tb/remote_station.sv
`default_nettype none
module remote_station (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // line pulled high between frames
  initial rxd_o = 1'b1;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // start low, data lsb first, ninth if 11 bits, then stop
  task automatic send(input logic [8:0] word, input int nbits, input int bclk,
                      input logic stop, input logic glitch);
    logic [10:0] f;
    f = {stop, word, 1'b0};
    f[nbits-1] = stop;
    for (int i = 0; i < nbits; i++) begin
      for (int c = 0; c < bclk; c++) begin
        // two-clock spike mid bit, meant to be outvoted
        rxd_o = (glitch && i > 0 && i < 9 && c >= bclk / 2 - 1 && c <= bclk / 2) ? !f[i] : f[i];
        wait_clk(1);
      end
    end
    rxd_o = 1'b1;
  endtask
  // false start: too short to survive the start vote
  task automatic blip();
    rxd_o = 1'b0;
    wait_clk(6);
    rxd_o = 1'b1;
    wait_clk(40);
  endtask
  task automatic capture(input int nbits, input int bclk, output logic [10:0] f);
    int w;
    f = '1;
    w = 0;
    // sample each bit near its middle, half a bit time after the start edge
    while (txd_i !== 1'b0 && w < 20000) begin
      wait_clk(1);
      w++;
    end
    wait_clk(bclk / 2);
    for (int i = 0; i < nbits; i++) begin
      f[i] = txd_i;
      if (i < nbits - 1) begin
        wait_clk(bclk);
      end
    end
  endtask
endmodule // remote_station
`default_nettype wire

// ===== tb/tb_async_serial_port.sv
`default_nettype none
module tb_async_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i, multiproc_select_i, rx_enable_i, baud_doubler_i, tx_ninth_bit_i, tx_valid_i;
  logic tx_done_clear_i, rx_done_clear_i, rx_read_i, framing_error_clear_i, rx_overrun_clear_i;
  logic [1:0] mode_i;
  logic [3:0] baud_fine_trim_reg_i;
  logic [7:0] slave_address_value_i, slave_address_mask_i, baud_reload_high_i;
  logic [7:0] baud_reload_low_i, tx_data_i, serial_data_buffer_o;
  logic rxd, txd_o, tx_ready_o, shift_tick_o, tx_done_flag_o, rx_done_flag_o, rx_ninth_bit_o;
  logic framing_error_flag_o, rx_overrun_flag_o;
  int miscompares = 0;
  int checks = 0;
  always #10 clk_i = ~clk_i;
  async_serial_port #(.FIFO_DEPTH(16)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .multiproc_select_i(multiproc_select_i),
    .rx_enable_i(rx_enable_i), .baud_doubler_i(baud_doubler_i), .tx_ninth_bit_i(tx_ninth_bit_i),
    .slave_address_value_i(slave_address_value_i), .slave_address_mask_i(slave_address_mask_i),
    .baud_reload_high_i(baud_reload_high_i), .baud_reload_low_i(baud_reload_low_i),
    .baud_fine_trim_reg_i(baud_fine_trim_reg_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .tx_done_clear_i(tx_done_clear_i),
    .rx_done_clear_i(rx_done_clear_i), .rx_read_i(rx_read_i),
    .framing_error_clear_i(framing_error_clear_i), .rx_overrun_clear_i(rx_overrun_clear_i),
    .rxd_i(rxd), .txd_o(txd_o), .shift_tick_o(shift_tick_o), .tx_done_flag_o(tx_done_flag_o),
    .rx_done_flag_o(rx_done_flag_o), .serial_data_buffer_o(serial_data_buffer_o),
    .rx_ninth_bit_o(rx_ninth_bit_o), .framing_error_flag_o(framing_error_flag_o),
    .rx_overrun_flag_o(rx_overrun_flag_o)
  );
  remote_station partner_u (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));
  // {address, mask, ninth and byte, taken}
  logic [25:0] addr_tbl [7] = '{{8'ha4, 8'hfa, 9'h1a0, 1'h1}, {8'ha4, 8'hfa, 9'h1a2, 1'h0},
    {8'ha4, 8'hfa, 9'h1ff, 1'h1}, {8'ha4, 8'hfa, 9'h0a0, 1'h0}, {8'h00, 8'h00, 9'h15a, 1'h1},
    {8'ha7, 8'hf9, 9'h1a3, 1'h1}, {8'ha7, 8'hf9, 9'h1a0, 1'h0}};
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pulse_clears();
    {tx_done_clear_i, rx_done_clear_i, rx_read_i, framing_error_clear_i, rx_overrun_clear_i} = '1;
    tick(1);
    {tx_done_clear_i, rx_done_clear_i, rx_read_i, framing_error_clear_i, rx_overrun_clear_i} = '0;
  endtask
  task automatic burst(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      tx_data_i = base + 8'(i);
      tx_ninth_bit_i = i[0];
      tx_valid_i = 1'b1;
      check({10'h0, tx_ready_o}, 11'h001, "push refused");
      tick(1);
    end
    tx_valid_i = 1'b0;
  endtask
  task automatic expect_rx(input logic done, input logic [8:0] word);
    tick(3);
    check({10'h0, rx_done_flag_o}, {10'h0, done}, "rx done");
    if (done) check({2'h0, rx_ninth_bit_o, serial_data_buffer_o}, {2'h0, word}, "rx word");
    pulse_clears();
  endtask
  task automatic t_tx_fixed();
    logic [10:0] f;
    mode_i = serial_port_pkg::MODE_FIX11;
    for (int s = 0; s < 2; s++) begin
      baud_doubler_i = s[0];
      burst(2, 8'ha5);
      for (int k = 0; k < 2; k++) begin
        partner_u.capture(11, s ? 32 : 64, f);
        check(f, {1'h1, k[0], 8'ha5 + 8'(k), 1'h0}, "fixed frame");
        check({10'h0, tx_done_flag_o}, 11'h001, "tx done at stop");
        pulse_clears();
      end
    end
    // let the last stop bit finish before the mode changes
    tick(64);
  endtask
  task automatic t_tx_var();
    logic [10:0] f;
    mode_i = serial_port_pkg::MODE_VAR10;
    baud_reload_low_i = 8'hfe;
    baud_fine_trim_reg_i = 4'h3;
    burst(17, 8'h10);
    tick(100);
    check({9'h0, tx_ready_o, txd_o}, 11'h001, "generator off");
    baud_reload_high_i = 8'hff;
    for (int k = 0; k < 17; k++) begin
      partner_u.capture(10, 35, f);
      check(f, {2'h3, 8'h10 + 8'(k), 1'h0}, "variable frame");
    end
    tick(60);
    check({10'h0, tx_ready_o}, 11'h001, "not drained");
    pulse_clears();
  endtask
  task automatic t_rx1();
    partner_u.send(9'h13c, 10, 35, 1'h1, 1'h0);
    expect_rx(1'h0, 9'h13c);
    rx_enable_i = 1'b1;
    partner_u.send(9'h13c, 10, 35, 1'h1, 1'h1);
    expect_rx(1'h1, 9'h13c);
    partner_u.blip();
    partner_u.send(9'h1c3, 10, 35, 1'h1, 1'h0);
    expect_rx(1'h1, 9'h1c3);
    partner_u.send(9'h155, 10, 35, 1'h0, 1'h0);
    expect_rx(1'h1, 9'h055);
    // idle long enough for the hunt to see the line high again
    tick(40);
    multiproc_select_i = 1'b1;
    partner_u.send(9'h155, 10, 35, 1'h0, 1'h0);
    tick(3);
    check({10'h0, framing_error_flag_o}, 11'h001, "framing error");
    expect_rx(1'h0, 9'h155);
    multiproc_select_i = 1'b0;
  endtask
  task automatic t_overrun();
    partner_u.send(9'h111, 10, 35, 1'h1, 1'h0);
    partner_u.send(9'h122, 10, 35, 1'h1, 1'h0);
    tick(3);
    check({2'h0, rx_ninth_bit_o, serial_data_buffer_o}, 11'h111, "held word");
    rx_done_clear_i = 1'b1;
    tick(1);
    rx_done_clear_i = 1'b0;
    partner_u.send(9'h133, 10, 35, 1'h1, 1'h0);
    tick(3);
    check({10'h0, rx_overrun_flag_o}, 11'h001, "overrun");
    expect_rx(1'h1, 9'h133);
  endtask
  task automatic t_addr();
    mode_i = serial_port_pkg::MODE_VAR11;
    multiproc_select_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      {slave_address_value_i, slave_address_mask_i} = addr_tbl[i][25:10];
      partner_u.send(addr_tbl[i][9:1], 11, 35, 1'h1, 1'h0);
      expect_rx(addr_tbl[i][0], addr_tbl[i][9:1]);
    end
  endtask
  task automatic t_shift();
    int n;
    for (int s = 0; s < 3; s++) begin
      rst_i = 1'b1;
      mode_i = (s < 2) ? serial_port_pkg::MODE_SHIFT : serial_port_pkg::MODE_FIX11;
      multiproc_select_i = s[0];
      tick(6);
      rst_i = 1'b0;
      n = 0;
      for (int c = 0; c < 132 && s < 2; c++) begin
        tick(1);
        n += int'(shift_tick_o);
      end
      if (s < 2) check(11'(n), s ? 11'h021 : 11'h00b, "shift ticks");
    end
  endtask
  initial begin
    rst_i = 1'b1;
    mode_i = serial_port_pkg::MODE_FIX11;
    {multiproc_select_i, rx_enable_i, baud_doubler_i, tx_ninth_bit_i, tx_valid_i} = '0;
    {tx_done_clear_i, rx_done_clear_i, rx_read_i, framing_error_clear_i, rx_overrun_clear_i} = '0;
    {slave_address_value_i, slave_address_mask_i, baud_reload_low_i, tx_data_i} = '0;
    baud_reload_high_i = 8'h7f;
    baud_fine_trim_reg_i = 4'h0;
    tick(6);
    rst_i = 1'b0;
    check({txd_o, tx_ready_o, tx_done_flag_o, rx_done_flag_o, framing_error_flag_o,
      rx_overrun_flag_o, shift_tick_o, 4'h0}, 11'h600, "reset state");
    t_tx_fixed();
    t_tx_var();
    t_rx1();
    t_overrun();
    t_addr();
    t_shift();
    final_report();
  end
  // whole run is near 15k clocks; allow over three times that
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
endmodule // tb_async_serial_port
`default_nettype wire
